//--- ops_pkg.sv
`default_nettype none
package ops_pkg;
  // Panel geometry
  localparam int STROBE_LINES = 8; // Shared strobe and LED lines
  localparam int RETURN_LINES = 4; // Key return lines
  localparam int KEY_COUNT = STROBE_LINES * RETURN_LINES; // 32 keys

  // System clock
  localparam int CLK_PERIOD_NS = 8; // 125 MHz

  // Least settle time of a strobe line before its returns are sampled
  localparam int STROBE_SETTLE_NS = 1000;
  localparam int STROBE_SETTLE_CYC =
    (STROBE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Least blanking time after the LEDs are gated off
  localparam int GATE_BLANK_NS = 200;
  localparam int GATE_BLANK_CYC =
    (GATE_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Least width of an LCD select pulse
  localparam int LCD_PULSE_NS = 240;
  localparam int LCD_PULSE_CYC =
    (LCD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // LED display time between two scans (above 4096 cycles)
  localparam int LED_PHASE_US = 1000;
  localparam int LED_PHASE_CYC = LED_PHASE_US * 1000 / CLK_PERIOD_NS;

  // Reset values of the panel outputs
  localparam logic [7:0] PANEL_BUS_RST = 8'h00;
  localparam logic LED_GATE_RST = 1'b0;
  localparam logic LCD_SELECT_RST = 1'b0;

  // Sequencer states, Gray along the scan path
  typedef enum logic [2:0] {
    OPS_LED    = 3'h0,
    OPS_BLANK  = 3'h1,
    OPS_STROBE = 3'h3,
    OPS_SAMPLE = 3'h2,
    OPS_LCD    = 3'h6
  } ops_state_t;

  // Pins toward the panel
  typedef struct packed {
    logic [7:0] panelOutBus; // Strobe, LED or LCD data
    logic ledGate;           // High lets the LEDs light
    logic lcdSelect;         // High qualifies bus data to the LCD
  } ops_panel_out_t;

  // LCD transfer request from the controller
  typedef struct packed {
    logic valid;     // Request a transfer
    logic [7:0] data; // Byte for the display module
  } ops_lcd_req_t;
endpackage : ops_pkg
`default_nettype wire

//--- ops_key_store.sv
`default_nettype none
// Key row memory with registered read
module ops_key_store #(
  parameter int WORDS = 8,
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Write port
  input wire logic writeEn,
  input wire logic [$clog2(WORDS)-1:0] writeAddr,
  input wire logic [WIDTH-1:0] writeData,
  // Read port
  input wire logic [$clog2(WORDS)-1:0] readAddr,
  output logic [WIDTH-1:0] readData_q
);
  // Row storage, cleared by reset so no phantom keys show
  logic [WIDTH-1:0] mem_q [WORDS];

  // Refuse shapes the address logic cannot serve
  if (WORDS < 2 || WIDTH < 1) begin : g_bad
    $error("ops_key_store: bad WORDS or WIDTH");
  end

  // Writes
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < WORDS; i++) mem_q[i] <= '0;
    end else if (writeEn) begin
      mem_q[writeAddr] <= writeData;
    end
  end

  // Registered read
  always_ff @(posedge clock) begin
    if (rst) readData_q <= '0;
    else readData_q <= mem_q[readAddr];
  end
endmodule : ops_key_store
`default_nettype wire

//--- ops_panel_scan.sv
`default_nettype none
module ops_panel_scan #(
  parameter int LED_CYCLES = ops_pkg::LED_PHASE_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Controller side
  input wire logic scanEnable,
  input wire logic [7:0] ledPattern,
  input wire ops_pkg::ops_lcd_req_t lcdReq,
  output logic lcdReady,
  input wire logic [2:0] keyRowAddr,
  output logic [3:0] keyRowData,
  output logic keyAny,
  output logic scanDone,
  // Panel side
  input wire logic [3:0] panelInBus,
  output var ops_pkg::ops_panel_out_t panelOut
);
  import ops_pkg::*;

  // Longest phase the timer must hold; a short LED phase must not
  // shrink the counter below the strobe settle time
  localparam int MAX_PHASE = (LED_CYCLES > STROBE_SETTLE_CYC) ?
    LED_CYCLES : STROBE_SETTLE_CYC;
  // Down counter wide enough for every phase
  localparam int CW = $clog2(MAX_PHASE + 1) + 1;

  // Refuse a zero phase or one the counter cannot hold
  if (LED_CYCLES < 1 || STROBE_SETTLE_CYC < 1 || GATE_BLANK_CYC < 1
      || LCD_PULSE_CYC < 1 || GATE_BLANK_CYC > MAX_PHASE
      || LCD_PULSE_CYC > MAX_PHASE) begin : g_bad
    $error("ops_panel_scan: phase lengths the timer cannot serve");
  end

  ops_state_t state_q, state_d; // Sequencer
  logic [CW-1:0] cnt_q, cnt_d;  // Phase timer
  logic [2:0] line_q, line_d;   // Strobe line in use
  logic [7:0] lcdData_q;        // Latched LCD byte
  logic [STROBE_LINES-1:0] rowHit_q; // Lines with a pressed key
  logic doneP_q;                // Frame complete pulse
  ops_panel_out_t out_d;        // Next pin values

  // Decode helpers
  wire cntZero = (cnt_q == '0);
  wire lastLine = (line_q == 3'(STROBE_LINES - 1));
  wire inLed = (state_q == OPS_LED);
  wire takeLcd = inLed && lcdReq.valid;
  wire startScan = inLed && cntZero && scanEnable && !lcdReq.valid;
  wire rowWrite = (state_q == OPS_SAMPLE);

  // One-hot strobe for a line
  function automatic logic [7:0] strobe_of(input logic [2:0] ln);
    strobe_of = 8'h01 << ln;
  endfunction : strobe_of

  // LCD requests are taken only from the LED phase
  assign lcdReady = inLed;

  // Next state and timer
  always_comb begin
    state_d = state_q;
    cnt_d = cntZero ? cnt_q : cnt_q - CW'(1);
    line_d = line_q;
    case (state_q)
      OPS_LED: begin
        if (takeLcd) begin // LCD wins over a scan start
          state_d = OPS_LCD;
          cnt_d = CW'(LCD_PULSE_CYC - 1);
        end else if (startScan) begin // Gate LEDs off first
          state_d = OPS_BLANK;
          cnt_d = CW'(GATE_BLANK_CYC - 1);
          line_d = 3'h0;
        end
      end
      OPS_BLANK: begin
        if (cntZero) begin // First strobe after blanking
          state_d = OPS_STROBE;
          cnt_d = CW'(STROBE_SETTLE_CYC - 1);
        end
      end
      OPS_STROBE: begin
        if (cntZero) state_d = OPS_SAMPLE; // Held long enough
      end
      OPS_SAMPLE: begin
        if (lastLine) begin // Frame over, back to LEDs
          state_d = OPS_LED;
          cnt_d = CW'(LED_CYCLES - 1);
        end else begin // Next line only after recording
          state_d = OPS_STROBE;
          line_d = line_q + 3'h1;
          cnt_d = CW'(STROBE_SETTLE_CYC - 1);
        end
      end
      OPS_LCD: begin
        if (cntZero) begin // Return without skipping the LED time
          state_d = OPS_LED;
          cnt_d = CW'(LED_CYCLES - 1);
        end
      end
      default: begin
        state_d = OPS_LED;
        cnt_d = '0;
      end
    endcase
  end

  // Pin values follow the next state, so pins change with the state
  always_comb begin
    out_d.lcdSelect = 1'b0;
    out_d.ledGate = 1'b0;
    out_d.panelOutBus = 8'h00;
    case (state_d)
      OPS_LED: begin // Shared lines show the LEDs
        out_d.ledGate = 1'b1;
        out_d.panelOutBus = ledPattern;
      end
      OPS_STROBE, OPS_SAMPLE: begin // One line at a time
        out_d.panelOutBus = strobe_of(line_d);
      end
      OPS_LCD: begin // Bus carries the byte under select
        out_d.lcdSelect = 1'b1;
        out_d.panelOutBus = takeLcd ? lcdReq.data : lcdData_q;
      end
      default: begin // Blanking keeps all lines low
        out_d.panelOutBus = 8'h00;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= OPS_LED;
      cnt_q <= '0;
      line_q <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      line_q <= line_d;
    end
  end

  // Pin registers; gate starts low so nothing glows out of reset
  always_ff @(posedge clock) begin
    if (rst) begin
      panelOut.panelOutBus <= PANEL_BUS_RST;
      panelOut.ledGate <= LED_GATE_RST;
      panelOut.lcdSelect <= LCD_SELECT_RST;
    end else begin
      panelOut <= out_d;
    end
  end

  // LCD byte latched when taken
  always_ff @(posedge clock) begin
    if (rst) lcdData_q <= 8'h00;
    else if (takeLcd) lcdData_q <= lcdReq.data;
  end

  // Summary of pressed lines, updated each sample
  always_ff @(posedge clock) begin
    if (rst) rowHit_q <= '0;
    else if (rowWrite) rowHit_q[line_q] <= |panelInBus;
  end
  assign keyAny = |rowHit_q;

  // Frame complete pulse
  always_ff @(posedge clock) begin
    if (rst) doneP_q <= 1'b0;
    else doneP_q <= rowWrite && lastLine;
  end
  assign scanDone = doneP_q;

  // Each row of four returns is one word: 8 x 4 = 32 keys
  ops_key_store #(
    .WORDS(STROBE_LINES),
    .WIDTH(RETURN_LINES)
  ) u_keys (
    .clock(clock),
    .rst(rst),
    .writeEn(rowWrite),
    .writeAddr(line_q),
    .writeData(panelInBus),
    .readAddr(keyRowAddr),
    .readData_q(keyRowData)
  );

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_strobe_hold;
    (state_q == OPS_STROBE && cntZero) ##1 (state_q == OPS_SAMPLE);
  endsequence

  a_gate_off_scan: assert property (
    (state_q inside {OPS_BLANK, OPS_STROBE, OPS_SAMPLE, OPS_LCD})
      |-> !panelOut.ledGate)
    else $error("LEDs enabled during strobing");

  a_strobe_one_hot: assert property (
    (state_q inside {OPS_STROBE, OPS_SAMPLE})
      |-> panelOut.panelOutBus == (8'h01 << line_q))
    else $error("Strobe pattern is not the current line");

  a_strobe_held: assert property (
    $rose(state_q == OPS_STROBE) |->
      (panelOut.panelOutBus == strobe_of(line_q)) ##1
      ($stable(panelOut.panelOutBus))[*8])
    else $error("Strobe line moved before settling");

  a_sample_records: assert property (
    s_strobe_hold |=> ##1 (u_keys.mem_q[$past(line_q, 2)]
      == $past(panelInBus, 2)))
    else $error("Key returns not recorded");

  a_line_advance: assert property (
    (state_q == OPS_SAMPLE && !lastLine)
      |=> state_q == OPS_STROBE && line_q == $past(line_q) + 3'h1)
    else $error("Strobe did not advance by one line");

  a_led_display: assert property (
    (state_q == OPS_LED && $past(state_q) == OPS_LED && !$past(rst))
      |-> panelOut.ledGate && panelOut.panelOutBus == $past(ledPattern))
    else $error("LED pattern not driven in LED phase");

  a_led_share: assert property (
    (state_q == OPS_SAMPLE && lastLine)
      |=> (state_q == OPS_LED && panelOut.ledGate && scanDone)
      ##1 !scanDone)
    else $error("Lines not returned to LEDs after a frame");

  a_lcd_qualify: assert property (
    takeLcd |=> (panelOut.panelOutBus == $past(lcdReq.data)) ##0
      (panelOut.lcdSelect && !panelOut.ledGate
      && panelOut.panelOutBus == lcdData_q)[*8])
    else $error("LCD select or byte wrong");

  a_blank_time: assert property (
    startScan |=> (state_q == OPS_BLANK)[*8])
    else $error("Blanking shorter than its least time");
endmodule : ops_panel_scan
`default_nettype wire

//--- ops_panel_model.sv
`default_nettype none
// Keypad matrix behind diodes and the LED row
module ops_panel_model (
  // Pins from the controller
  input wire ops_pkg::ops_panel_out_t panelOut,
  // Keys held down, bit 4*line+return
  input wire logic [31:0] keyMask,
  // Pins back to the controller
  output logic [3:0] panelInBus,
  output logic [7:0] ledLit
);
  timeunit 1ns;
  timeprecision 1ps;
  import ops_pkg::*;

  // Direct 8x4 part only; wider arrays need outside logic
  // Returns are pulled low; a key ties its strobe to its return
  always_comb begin
    for (int r = 0; r < RETURN_LINES; r++) begin
      panelInBus[r] = 1'b0;
      for (int n = 0; n < STROBE_LINES; n++) begin
        panelInBus[r] |= panelOut.panelOutBus[n] & keyMask[4*n+r];
      end
    end
  end

  // LEDs glow only while the gate lets current through
  assign ledLit = panelOut.ledGate ? panelOut.panelOutBus : 8'h00;
endmodule : ops_panel_model
`default_nettype wire

//--- tb_ops_panel_scan.sv
`default_nettype none
module tb_ops_panel_scan;
  timeunit 1ns;
  timeprecision 1ps;
  import ops_pkg::*;
  localparam int LEDCYC = 50; // Short LED phase keeps the run brief
  localparam int LIMIT = 20000; // Cycle ceiling for the whole run
  // Clock, reset and controller side
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic scanEnable = 1'b0;
  logic [7:0] ledPattern = 8'h00;
  ops_lcd_req_t lcdReq = '0;
  logic lcdReady;
  logic [2:0] keyRowAddr = 3'h0;
  logic [3:0] keyRowData;
  logic keyAny;
  logic scanDone;
  // Panel side
  logic [3:0] panelInBus;
  ops_panel_out_t panelOut;
  logic [31:0] keyMask = 32'h0;
  logic [7:0] ledLit;
  // Bookkeeping
  int failCount = 0;
  int nTests = 0;
  int cyc = 0;

  ops_panel_scan #(.LED_CYCLES(LEDCYC)) dut (.clock(clock), .rst(rst),
    .scanEnable(scanEnable), .ledPattern(ledPattern), .lcdReq(lcdReq),
    .lcdReady(lcdReady), .keyRowAddr(keyRowAddr), .keyRowData(keyRowData),
    .keyAny(keyAny), .scanDone(scanDone), .panelInBus(panelInBus),
    .panelOut(panelOut));

  ops_panel_model panel (.panelOut(panelOut), .keyMask(keyMask),
    .panelInBus(panelInBus), .ledLit(ledLit));

  // System clock
  always #(CLK_PERIOD_NS / 2) clock = ~clock;

  task automatic check(input string what, input logic [31:0] exp, got);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wrapUp();
    if (failCount == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrapUp

  // LED image shows on the shared lines while gated on
  task automatic ledShow();
    ledPattern = 8'ha5;
    repeat (2) @(negedge clock);
    check("panelOutBus", 8'ha5, panelOut.panelOutBus);
    check("ledLit", 8'ha5, ledLit);
  endtask : ledShow

  // One byte to the display, width of the select pulse counted
  task automatic lcdWrite(input logic [7:0] b);
    int n;
    lcdReq.data = b;
    lcdReq.valid = 1'b1;
    n = 0;
    while (lcdReady !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    lcdReq.valid = 1'b0;
    check("lcdReady busy", 1'b0, lcdReady);
    n = 0;
    while (panelOut.lcdSelect === 1'b1 && n < 100) begin
      check("lcd byte", b, panelOut.panelOutBus);
      n++;
      @(negedge clock);
    end
    check("lcd width", LCD_PULSE_CYC, n);
    check("lcdReady free", 1'b1, lcdReady);
  endtask : lcdWrite

  // Full frame: strobe order, hold time, dark LEDs, stored returns
  task automatic scanFrame(input logic [31:0] mask);
    int n;
    int len;
    keyMask = mask;
    scanEnable = 1'b1;
    n = 0;
    while (panelOut.ledGate !== 1'b0 && n < 200) begin
      @(negedge clock);
      n++;
    end
    // A started scan cannot stop, so the enable may drop now
    scanEnable = 1'b0;
    for (int line = 0; line < STROBE_LINES; line++) begin
      n = 0;
      while (panelOut.panelOutBus !== (8'h01 << line) && n < 200) begin
        check("ledLit blank", 8'h00, ledLit);
        @(negedge clock);
        n++;
      end
      len = 0;
      while (panelOut.panelOutBus === (8'h01 << line) && len < 300) begin
        check("ledLit strobe", 8'h00, ledLit);
        len++;
        @(negedge clock);
      end
      check("strobe hold", STROBE_SETTLE_CYC + 1, len);
    end
    n = 0;
    while (scanDone !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    check("scanDone", 1'b1, scanDone);
    check("ledLit after", ledPattern, ledLit);
    check("keyAny", |mask, keyAny);
    for (int line = 0; line < STROBE_LINES; line++) begin
      keyRowAddr = 3'(line);
      @(negedge clock);
      check("keyRowData", mask[4*line +: 4], keyRowData);
    end
  endtask : scanFrame

  // Cut a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failCount++;
      wrapUp();
    end
  end

  // Main sequence
  initial begin
    repeat (3) @(negedge clock);
    check("reset bus", PANEL_BUS_RST, panelOut.panelOutBus);
    check("reset gate", LED_GATE_RST, panelOut.ledGate);
    check("reset select", LCD_SELECT_RST, panelOut.lcdSelect);
    rst = 1'b0;
    ledShow();
    lcdWrite(8'h3c);
    lcdWrite(8'hc3);
    // Two opposite corner keys of the matrix plus one inside
    scanFrame(32'h8000_2001);
    scanFrame(32'h0000_0000);
    wrapUp();
  end
endmodule : tb_ops_panel_scan
`default_nettype wire
